/* File: tmo_pkg.sv */
package tmo_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [3:0] ADDR_CTRL_FIRST = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CAP_ONE_HI = 4'h3;
  localparam logic [3:0] ADDR_CAP_ONE_LO = 4'h4;
  localparam logic [3:0] ADDR_CMP_ONE_HI = 4'h5;
  localparam logic [3:0] ADDR_CMP_ONE_LO = 4'h6;
  localparam logic [3:0] ADDR_CNT_HI = 4'h7;
  localparam logic [3:0] ADDR_CNT_LO = 4'h8;
  localparam logic [3:0] ADDR_ALT_HI = 4'h9;
  localparam logic [3:0] ADDR_ALT_LO = 4'ha;
  localparam logic [3:0] ADDR_CAP_TWO_HI = 4'hb;
  localparam logic [3:0] ADDR_CAP_TWO_LO = 4'hc;
  localparam logic [3:0] ADDR_CMP_TWO_HI = 4'hd;
  localparam logic [3:0] ADDR_CMP_TWO_LO = 4'he;

  // First control register fields.
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_OVF_IRQ_EN = 5;
  localparam int C1_FORCE_TWO = 4;
  localparam int C1_FORCE_ONE = 3;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_EDGE_ONE = 1;
  localparam int C1_LEVEL_ONE = 0;

  // Second control register fields.
  localparam int C2_PIN_EN_ONE = 7;
  localparam int C2_PIN_EN_TWO = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_DIV_HI = 3;
  localparam int C2_DIV_LO = 2;
  localparam int C2_EDGE_TWO = 1;
  localparam int C2_EXT_EDGE = 0;

  // Status register fields.
  localparam int ST_CAP_ONE = 7;
  localparam int ST_CMP_ONE = 6;
  localparam int ST_OVF = 5;
  localparam int ST_CAP_TWO = 4;
  localparam int ST_CMP_TWO = 3;

  // Tick divider select encodings.
  localparam logic [1:0] DIV_BY_TWO = 2'h0;
  localparam logic [1:0] DIV_BY_FOUR = 2'h1;
  localparam logic [1:0] DIV_BY_EIGHT = 2'h2;
  localparam logic [1:0] DIV_EXTERNAL = 2'h3;

  // Reset and reload values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CAP_ONE_PULSE_VALUE = 16'hfffd;
  localparam logic [15:0] CAP_RESET = 16'h0000;

endpackage

/* File: tmo_timer_compare.sv */
`timescale 1ns/1ps

module tmo_timer_compare #(
  parameter int ADDR_W = 4
) (
  // Clock, reset and freeze.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // CPU interrupt mask and timer interrupt request.
  input wire logic cpuIrqMask,
  output logic timerIrq,
  // Trigger and clock pins from outside.
  input wire logic captureInPinOne,
  input wire logic captureInPinTwo,
  input wire logic extClkPin,
  // Compare pins, enable low while the timer drives them.
  output logic [1:0] compareOutPin,
  output logic [1:0] compareOutPinOeN
);
  import tmo_pkg::*;

  initial begin
    if (ADDR_W < 4) begin
      $error("ADDR_W must be at least 4");
    end
  end

  logic [7:0] ctrlFirst_q;
  logic [7:0] ctrlSecond_q;
  logic [15:0] cmpReg_q [2];
  logic [15:0] actCmp_q [2];
  logic [1:0] cmpHiPend_q;
  logic [15:0] cnt_q;
  logic [15:0] cntNext;
  logic [2:0] psc_q;
  logic [15:0] capOne_q;
  logic [15:0] capTwo_q;
  logic [1:0] capHiRead_q;
  logic [1:0] compareFlag_q;
  logic [1:0] cmpArm_q;
  logic [1:0] capFlag_q;
  logic [1:0] capArm_q;
  logic ovfFlag_q;
  logic ovfArm_q;
  logic [1:0] pinLatch_q;
  logic [7:0] rdData_q;
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic [2:0] syncDly_q;
  logic tick;
  logic divTwo;
  logic pwmMode;
  logic onePulseMode;
  logic [1:0] match;
  logic [1:0] level;
  logic capEdgeOne;
  logic capEdgeTwo;
  logic extEdge;
  logic onePulseTrigger;
  logic cntWrite;
  logic [1:0] cmpLoAccess;
  logic [1:0] cmpHiWrite;
  logic [1:0] capLoAccess;
  logic statusRead;
  logic cntLoAccess;
  logic ctrlFirstWrite;
  logic [1:0] capEvent;
  logic [1:0] cmpFlagSet;
  logic [1:0] forceApply;

  // Strobe decode; the top address bits must be zero for a hit.
  logic addrHigh;
  assign addrHigh = (regAddr >> 4) != '0;
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off, input logic hi);
    hit = !hi && (a[3:0] == off);
  endfunction
  assign statusRead = regRdStb && hit(regAddr, ADDR_STATUS, addrHigh);
  assign ctrlFirstWrite = regWrStb && hit(regAddr, ADDR_CTRL_FIRST, addrHigh);
  assign cntWrite = regWrStb && (hit(regAddr, ADDR_CNT_LO, addrHigh) || hit(regAddr, ADDR_ALT_LO, addrHigh));
  assign cntLoAccess = (regWrStb || regRdStb) && hit(regAddr, ADDR_CNT_LO, addrHigh);
  assign cmpLoAccess[0] = (regWrStb || regRdStb) && hit(regAddr, ADDR_CMP_ONE_LO, addrHigh);
  assign cmpLoAccess[1] = (regWrStb || regRdStb) && hit(regAddr, ADDR_CMP_TWO_LO, addrHigh);
  assign cmpHiWrite[0] = regWrStb && hit(regAddr, ADDR_CMP_ONE_HI, addrHigh);
  assign cmpHiWrite[1] = regWrStb && hit(regAddr, ADDR_CMP_TWO_HI, addrHigh);
  assign capLoAccess[0] = (regWrStb || regRdStb) && hit(regAddr, ADDR_CAP_ONE_LO, addrHigh);
  assign capLoAccess[1] = (regWrStb || regRdStb) && hit(regAddr, ADDR_CAP_TWO_LO, addrHigh);

  // Mode decode; pulse-width mode wins when both mode bits are set.
  assign pwmMode = ctrlSecond_q[C2_PWM];
  assign onePulseMode = ctrlSecond_q[C2_ONE_PULSE] && !pwmMode;
  assign level[0] = ctrlFirst_q[C1_LEVEL_ONE];
  assign level[1] = ctrlFirst_q[C1_LEVEL_TWO];

  // Pin synchronisers: stage A feeds only stage B, edges are taken from B and its delay.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      syncDly_q <= 3'h0;
    end else if (clkEn) begin
      syncA_q <= {extClkPin, captureInPinTwo, captureInPinOne};
      syncB_q <= syncA_q;
      syncDly_q <= syncB_q;
    end
  end

  // Active edges: the edge bit chooses rising when set, falling when clear.
  assign capEdgeOne = ctrlFirst_q[C1_EDGE_ONE] ? (syncB_q[0] && !syncDly_q[0]) : (!syncB_q[0] && syncDly_q[0]);
  assign capEdgeTwo = ctrlSecond_q[C2_EDGE_TWO] ? (syncB_q[1] && !syncDly_q[1]) : (!syncB_q[1] && syncDly_q[1]);
  assign extEdge = ctrlSecond_q[C2_EXT_EDGE] ? (syncB_q[2] && !syncDly_q[2]) : (!syncB_q[2] && syncDly_q[2]);
  assign onePulseTrigger = onePulseMode && capEdgeOne;

  // Prescaler runs freely so the tick phase never depends on the select bits.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      psc_q <= 3'h0;
    end else if (clkEn) begin
      psc_q <= psc_q + 3'h1;
    end
  end

  // Tick selection.
  always_comb begin
    divTwo = 1'b0;
    case (ctrlSecond_q[C2_DIV_HI:C2_DIV_LO])
      DIV_BY_TWO: begin
        tick = psc_q[0];
        divTwo = 1'b1;
      end
      DIV_BY_FOUR: tick = (psc_q[1:0] == 2'h3);
      DIV_BY_EIGHT: tick = (psc_q == 3'h7);
      DIV_EXTERNAL: tick = extEdge;
      default: tick = 1'b0;
    endcase
  end

  assign cntNext = cnt_q + 16'h0001;

  // Match is judged once per tick; divide by 2 fires as the counter reaches the value,
  // the slower ticks fire as it leaves it, so the effect shows at value plus one.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gCmp
      assign match[gi] = tick && !cmpHiPend_q[gi]
        && (divTwo ? (cntNext == actCmp_q[gi]) : (cnt_q == actCmp_q[gi]));

      // Software-owned compare value; hardware never writes it.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cmpReg_q[gi] <= CMP_RESET;
        end else if (clkEn) begin
          if (cmpHiWrite[gi]) begin
            cmpReg_q[gi][15:8] <= regWrData;
          end
          if (regWrStb && cmpLoAccess[gi]) begin
            cmpReg_q[gi][7:0] <= regWrData;
          end
        end
      end

      // A high byte write holds the compare off until the low byte completes the value.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cmpHiPend_q[gi] <= 1'b0;
        end else if (clkEn) begin
          if (cmpHiWrite[gi]) begin
            cmpHiPend_q[gi] <= 1'b1;
          end else if (regWrStb && cmpLoAccess[gi]) begin
            cmpHiPend_q[gi] <= 1'b0;
          end
        end
      end

      // Working copy: follows the register, but in pulse-width mode it is only
      // refreshed at the period end so a half-written pair never glitches the pin.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          actCmp_q[gi] <= CMP_RESET;
        end else if (clkEn) begin
          if (!pwmMode || match[1]) begin
            actCmp_q[gi] <= cmpReg_q[gi];
          end
        end
      end

      // Compare flag clearing arm: status read while set, then the low byte access.
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cmpArm_q[gi] <= 1'b0;
          compareFlag_q[gi] <= 1'b0;
        end else if (clkEn) begin
          if (statusRead && compareFlag_q[gi]) begin
            cmpArm_q[gi] <= 1'b1;
          end else if (cmpLoAccess[gi]) begin
            cmpArm_q[gi] <= 1'b0;
          end
          if (cmpFlagSet[gi]) begin
            compareFlag_q[gi] <= 1'b1;
          end else if (cmpArm_q[gi] && cmpLoAccess[gi]) begin
            compareFlag_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Flag one is never set in either special mode; flag two is lost only in pulse-width mode.
  assign cmpFlagSet[0] = match[0] && !onePulseMode && !pwmMode;
  assign cmpFlagSet[1] = match[1] && !pwmMode;

  // Capture events; capture one is disconnected in both special modes.
  assign capEvent[0] = capEdgeOne && !onePulseMode && !pwmMode && !capHiRead_q[0];
  assign capEvent[1] = capEdgeTwo && !capHiRead_q[1];

  // Capture registers; the one-pulse trigger loads a fixed value instead.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      capOne_q <= CAP_RESET;
      capTwo_q <= CAP_RESET;
    end else if (clkEn) begin
      if (onePulseTrigger) begin
        capOne_q <= CAP_ONE_PULSE_VALUE;
      end else if (capEvent[0]) begin
        capOne_q <= cnt_q;
      end
      if (capEvent[1]) begin
        capTwo_q <= cnt_q;
      end
    end
  end

  // Reading a capture high byte inhibits that capture until its low byte is read.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      capHiRead_q <= 2'h0;
    end else if (clkEn) begin
      if (regRdStb && hit(regAddr, ADDR_CAP_ONE_HI, addrHigh)) begin
        capHiRead_q[0] <= 1'b1;
      end else if (regRdStb && capLoAccess[0]) begin
        capHiRead_q[0] <= 1'b0;
      end
      if (regRdStb && hit(regAddr, ADDR_CAP_TWO_HI, addrHigh)) begin
        capHiRead_q[1] <= 1'b1;
      end else if (regRdStb && capLoAccess[1]) begin
        capHiRead_q[1] <= 1'b0;
      end
    end
  end

  // Capture flags; in pulse-width mode the period end also sets flag one.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      capFlag_q <= 2'h0;
      capArm_q <= 2'h0;
    end else if (clkEn) begin
      for (int k = 0; k < 2; k++) begin
        if (statusRead && capFlag_q[k]) begin
          capArm_q[k] <= 1'b1;
        end else if (capLoAccess[k]) begin
          capArm_q[k] <= 1'b0;
        end
      end
      if (capEvent[0] || onePulseTrigger || (pwmMode && match[1])) begin
        capFlag_q[0] <= 1'b1;
      end else if (capArm_q[0] && capLoAccess[0]) begin
        capFlag_q[0] <= 1'b0;
      end
      if (capEvent[1]) begin
        capFlag_q[1] <= 1'b1;
      end else if (capArm_q[1] && capLoAccess[1]) begin
        capFlag_q[1] <= 1'b0;
      end
    end
  end

  // Free-running counter with its three reload causes.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= CNT_RELOAD;
    end else if (clkEn) begin
      if (onePulseTrigger) begin
        cnt_q <= CNT_RELOAD;
      end else if (pwmMode && match[1]) begin
        cnt_q <= CNT_RELOAD;
      end else if (cntWrite) begin
        cnt_q <= CNT_RELOAD;
      end else if (tick) begin
        cnt_q <= cntNext;
      end
    end
  end

  // Overflow flag, set on roll-over, cleared by status read then counter low access.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovfFlag_q <= 1'b0;
      ovfArm_q <= 1'b0;
    end else if (clkEn) begin
      if (statusRead && ovfFlag_q) begin
        ovfArm_q <= 1'b1;
      end else if (cntLoAccess) begin
        ovfArm_q <= 1'b0;
      end
      if (tick && (cnt_q == 16'hffff) && !onePulseTrigger && !(pwmMode && match[1]) && !cntWrite) begin
        ovfFlag_q <= 1'b1;
      end else if (ovfArm_q && cntLoAccess) begin
        ovfFlag_q <= 1'b0;
      end
    end
  end

  // Control registers; force bits are acted on at the write and never stored.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrlFirst_q <= CTRL_RESET;
      ctrlSecond_q <= CTRL_RESET;
    end else if (clkEn) begin
      if (ctrlFirstWrite) begin
        ctrlFirst_q <= regWrData & ~(8'h01 << C1_FORCE_ONE) & ~(8'h01 << C1_FORCE_TWO);
      end
      if (regWrStb && hit(regAddr, ADDR_CTRL_SECOND, addrHigh)) begin
        ctrlSecond_q <= regWrData;
      end
    end
  end

  // Forcing takes the level written in the same cycle; blocked in the special modes.
  assign forceApply[0] = ctrlFirstWrite && regWrData[C1_FORCE_ONE] && !onePulseMode && !pwmMode;
  assign forceApply[1] = ctrlFirstWrite && regWrData[C1_FORCE_TWO] && !onePulseMode && !pwmMode;

  // Pin latches. Pin one follows the mode; pin two only in plain compare mode.
  // Pin one: when the level bits are equal, every event writes the same value.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinLatch_q <= 2'h0;
    end else if (clkEn) begin
      if (pwmMode) begin
        if (match[1]) begin
          pinLatch_q[0] <= level[1];
        end else if (match[0]) begin
          pinLatch_q[0] <= level[0];
        end
      end else if (onePulseMode) begin
        if (onePulseTrigger) begin
          pinLatch_q[0] <= level[1];
        end else if (match[0]) begin
          pinLatch_q[0] <= level[0];
        end
      end else begin
        if (forceApply[0]) begin
          pinLatch_q[0] <= regWrData[C1_LEVEL_ONE];
        end else if (match[0]) begin
          pinLatch_q[0] <= level[0];
        end
      end
      if (!onePulseMode && !pwmMode) begin
        if (forceApply[1]) begin
          pinLatch_q[1] <= regWrData[C1_LEVEL_TWO];
        end else if (match[1]) begin
          pinLatch_q[1] <= level[1];
        end
      end
    end
  end

  // The pin is released to the port logic whenever its enable bit is clear.
  assign compareOutPin = pinLatch_q;
  assign compareOutPinOeN[0] = !ctrlSecond_q[C2_PIN_EN_ONE];
  assign compareOutPinOeN[1] = !ctrlSecond_q[C2_PIN_EN_TWO];

  // One combined request; a pending flag raises it again once the mask drops.
  assign timerIrq = !cpuIrqMask && (
      (ctrlFirst_q[C1_CMP_IRQ_EN] && (compareFlag_q != 2'h0))
      || (ctrlFirst_q[C1_CAP_IRQ_EN] && (capFlag_q != 2'h0))
      || (ctrlFirst_q[C1_OVF_IRQ_EN] && ovfFlag_q));

  // Read data, registered so it stands in the cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= 8'h00;
      if (regRdStb && !addrHigh) begin
        case (regAddr[3:0])
          ADDR_CTRL_FIRST: rdData_q <= ctrlFirst_q;
          ADDR_CTRL_SECOND: rdData_q <= ctrlSecond_q;
          ADDR_STATUS: begin
            rdData_q[ST_CAP_ONE] <= capFlag_q[0];
            rdData_q[ST_CMP_ONE] <= compareFlag_q[0];
            rdData_q[ST_OVF] <= ovfFlag_q;
            rdData_q[ST_CAP_TWO] <= capFlag_q[1];
            rdData_q[ST_CMP_TWO] <= compareFlag_q[1];
          end
          ADDR_CAP_ONE_HI: rdData_q <= capOne_q[15:8];
          ADDR_CAP_ONE_LO: rdData_q <= capOne_q[7:0];
          ADDR_CMP_ONE_HI: rdData_q <= cmpReg_q[0][15:8];
          ADDR_CMP_ONE_LO: rdData_q <= cmpReg_q[0][7:0];
          ADDR_CNT_HI: rdData_q <= cnt_q[15:8];
          ADDR_CNT_LO: rdData_q <= cnt_q[7:0];
          ADDR_ALT_HI: rdData_q <= cnt_q[15:8];
          ADDR_ALT_LO: rdData_q <= cnt_q[7:0];
          ADDR_CAP_TWO_HI: rdData_q <= capTwo_q[15:8];
          ADDR_CAP_TWO_LO: rdData_q <= capTwo_q[7:0];
          ADDR_CMP_TWO_HI: rdData_q <= cmpReg_q[1][15:8];
          ADDR_CMP_TWO_LO: rdData_q <= cmpReg_q[1][7:0];
          default: rdData_q <= 8'h00;
        endcase
      end
    end
  end

  assign regRdData = rdData_q;

endmodule

/* File: tmo_timer_compare_props.sv */
`timescale 1ns/1ps

// Port-level checker; control bits are shadowed from register writes since the bodies are hidden.
module tmo_timer_compare_props #(
  parameter int ADDR_W = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // Interrupt.
  input wire logic cpuIrqMask,
  input wire logic timerIrq,
  // Pins.
  input wire logic captureInPinOne,
  input wire logic captureInPinTwo,
  input wire logic extClkPin,
  input wire logic [1:0] compareOutPin,
  input wire logic [1:0] compareOutPinOeN
);
  import tmo_pkg::*;

  logic wrCtrlOne;
  logic wrCtrlTwo;
  logic onePulseOn;
  logic modeOn;
  logic [7:0] ctrlOne_q;
  logic [7:0] ctrlTwo_q;

  // Write decode; a strobe with the clock enable low is dropped by the block, so it is ignored here.
  assign wrCtrlOne = clkEn && regWrStb && regAddr == ADDR_W'(ADDR_CTRL_FIRST);
  assign wrCtrlTwo = clkEn && regWrStb && regAddr == ADDR_W'(ADDR_CTRL_SECOND);
  assign modeOn = ctrlTwo_q[C2_ONE_PULSE] || ctrlTwo_q[C2_PWM];
  assign onePulseOn = ctrlTwo_q[C2_ONE_PULSE] && !ctrlTwo_q[C2_PWM];

  // Shadow copies of both control registers.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrlOne_q <= 8'h00;
      ctrlTwo_q <= 8'h00;
    end else begin
      if (wrCtrlOne) begin
        ctrlOne_q <= regWrData;
      end
      if (wrCtrlTwo) begin
        ctrlTwo_q <= regWrData;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  pin_reset_low_a: assert property (disable iff (1'b0) !rstn |-> compareOutPin == 2'h0 && compareOutPinOeN == 2'h3)
    else $error("compare pins not idle in reset");
  cmp_read_back_a: assert property (clkEn && regWrStb && regAddr == ADDR_W'(ADDR_CMP_ONE_HI) ##1 !regWrStb
    ##1 clkEn && regRdStb && regAddr == ADDR_W'(ADDR_CMP_ONE_HI) |=> regRdData == $past(regWrData, 3))
    else $error("compare byte read back differs from write");
  irq_masked_a: assert property (cpuIrqMask |-> !timerIrq)
    else $error("interrupt raised while masked");
  pin_enable_a: assert property (wrCtrlTwo |=> compareOutPinOeN[0] != $past(regWrData[C2_PIN_EN_ONE])
    && compareOutPinOeN[1] != $past(regWrData[C2_PIN_EN_TWO])) else $error("pin enable not applied");
  oe_stable_a: assert property (!wrCtrlTwo |=> $stable(compareOutPinOeN))
    else $error("pin enable moved without a write");
  force_level_a: assert property (wrCtrlOne && !modeOn && regWrData[C1_FORCE_ONE]
    |=> compareOutPin[0] == $past(regWrData[C1_LEVEL_ONE])) else $error("forced level not on pin one");
  pulse_pin_two_a: assert property (onePulseOn && $past(onePulseOn) |-> $stable(compareOutPin[1]))
    else $error("pin two moved in one-pulse mode");
  pulse_trigger_a: assert property (onePulseOn && ctrlOne_q[C1_EDGE_ONE] && $rose(captureInPinOne)
    |-> ##[1:5] compareOutPin[0] == ctrlOne_q[C1_LEVEL_TWO]) else $error("trigger did not start pulse");
endmodule

bind tmo_timer_compare tmo_timer_compare_props #(.ADDR_W(ADDR_W)) props (.clk_sys(clk_sys), .rstn(rstn),
  .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .cpuIrqMask(cpuIrqMask), .timerIrq(timerIrq), .captureInPinOne(captureInPinOne),
  .captureInPinTwo(captureInPinTwo), .extClkPin(extClkPin), .compareOutPin(compareOutPin),
  .compareOutPinOeN(compareOutPinOeN));

/* File: tmo_pin_partner.sv */
`timescale 1ns/1ps

// Pins around the timer: a trigger source on capture one, a quiet capture two and a free external clock.
module tmo_pin_partner (
  // Clock and command from the bench.
  input wire logic clk_sys,
  input wire logic fireOne,
  // Pins into the timer.
  output logic captureInPinOne,
  output logic captureInPinTwo,
  output logic extClkPin
);
  logic [3:0] highCnt_q = 4'h0;
  logic [3:0] extDiv_q = 4'h0;

  // External tick source: one falling edge every 16 clocks, well inside the synchroniser's reach.
  always_ff @(posedge clk_sys) begin
    extDiv_q <= extDiv_q + 4'h1;
  end

  // A trigger holds the pin high eight clocks, so the two-stage synchroniser cannot miss it.
  always_ff @(posedge clk_sys) begin
    if (fireOne) begin
      highCnt_q <= 4'h8;
    end else if (highCnt_q != 4'h0) begin
      highCnt_q <= highCnt_q - 4'h1;
    end
  end

  // Capture two stays low; the external clock may run free, the timer counts it only when selected.
  assign captureInPinOne = highCnt_q != 4'h0;
  assign captureInPinTwo = 1'b0;
  assign extClkPin = extDiv_q[3];
endmodule

/* File: tmo_timer_compare_test.sv */
`timescale 1ns/1ps

// Drives the compare block over its register port and checks pins, flags and the interrupt.
module tmo_timer_compare_test;
  import tmo_pkg::*;
  logic clk_sys, rstn, clkEn, regWrStb, regRdStb, cpuIrqMask, fireOne, timerIrq, capOne, capTwo, extClk;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [1:0] cmpPin, cmpOeN;
  int numErrors, testsRun;
  longint t0;

  tmo_timer_compare dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .cpuIrqMask(cpuIrqMask), .timerIrq(timerIrq),
    .captureInPinOne(capOne), .captureInPinTwo(capTwo), .extClkPin(extClk), .compareOutPin(cmpPin),
    .compareOutPinOeN(cmpOeN));
  tmo_pin_partner partner (.clk_sys(clk_sys), .fireOne(fireOne), .captureInPinOne(capOne),
    .captureInPinTwo(capTwo), .extClkPin(extClk));

  // Free-running 10 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask

  // The overflow bit sets on every pass through zero, so status compares leave it out.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    logic [7:0] seen;
    @(posedge clk_sys);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    seen = regRdData;
    if (a == ADDR_STATUS) seen[ST_OVF] = 1'b0;
    chk(name, {8'h00, seen}, {8'h00, exp});
  endtask

  // Waits for a rising edge on compare pin one, bounded.
  task automatic waitRise;
    int n;
    n = 0;
    while (cmpPin[0] !== 1'b0 && n < 3000) begin @(posedge clk_sys); #1; n++; end
    while (cmpPin[0] !== 1'b1 && n < 3000) begin @(posedge clk_sys); #1; n++; end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The planned run is a few thousand cycles; this limit is several times that.
  initial begin
    #2000000;
    numErrors++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim;
  end

  initial begin
    {rstn, regWrStb, regRdStb, fireOne, regAddr, regWrData} = '0;
    {clkEn, cpuIrqMask} = 2'h3;
    numErrors = 0;
    testsRun = 0;
    repeat (20) @(posedge clk_sys);
    chk("reset pins", {12'h0, cmpPin, cmpOeN}, 16'h0003);
    rstn <= 1'b1;
    rd(ADDR_CMP_ONE_HI, 8'h80, "cmp1 hi");
    rd(ADDR_CMP_ONE_LO, 8'h00, "cmp1 lo");
    rd(ADDR_CMP_TWO_HI, 8'h80, "cmp2 hi");
    rd(ADDR_CMP_TWO_LO, 8'h00, "cmp2 lo");
    rd(4'hf, 8'h00, "unmapped");
    wr(ADDR_CMP_ONE_HI, 8'h7f);
    rd(ADDR_CMP_ONE_HI, 8'h7f, "cmp1 hi back");
    wr(ADDR_CMP_ONE_LO, 8'h10);
    rd(ADDR_CMP_ONE_LO, 8'h10, "cmp1 lo back");
    $display("test reset and read back done");
    wr(ADDR_CTRL_SECOND, 8'hc0);
    wr(ADDR_CTRL_FIRST, 8'h1d);
    tick(1);
    chk("forced pins", {12'h0, cmpPin, cmpOeN}, 16'h000c);
    rd(ADDR_CTRL_FIRST, 8'h05, "ctrl1 force reads 0");
    rd(ADDR_STATUS, 8'h00, "no flag on force");
    wr(ADDR_CTRL_FIRST, 8'h18);
    tick(1);
    chk("forced low", 16'(cmpPin), 16'h0000);
    $display("test force done");
    wr(ADDR_CTRL_FIRST, 8'h41);
    wr(ADDR_CMP_ONE_HI, 8'h00);
    rd(ADDR_STATUS, 8'h00, "status before update");
    wr(ADDR_CMP_ONE_LO, 8'h10);
    wr(ADDR_CNT_LO, 8'h00);
    tick(50);
    chk("match pin", {15'h0, cmpPin[0]}, 16'h0001);
    chk("irq masked", {15'h0, timerIrq}, 16'h0000);
    rd(ADDR_STATUS, 8'h40, "match flag");
    @(posedge clk_sys);
    cpuIrqMask <= 1'b0;
    tick(1);
    chk("irq unmasked", {15'h0, timerIrq}, 16'h0001);
    rd(ADDR_CMP_ONE_LO, 8'h10, "cmp1 lo clear");
    rd(ADDR_STATUS, 8'h00, "flag cleared");
    chk("irq cleared", {15'h0, timerIrq}, 16'h0000);
    $display("test match and interrupt done");
    wr(ADDR_CTRL_FIRST, 8'h40);
    wr(ADDR_CMP_ONE_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    tick(50);
    rd(ADDR_STATUS, 8'h00, "suppressed flag");
    chk("suppressed pin", {15'h0, cmpPin[0]}, 16'h0001);
    wr(ADDR_CTRL_SECOND, 8'h00);
    wr(ADDR_CMP_ONE_LO, 8'h10);
    wr(ADDR_CNT_LO, 8'h00);
    tick(50);
    chk("released oe", {14'h0, cmpOeN}, 16'h0003);
    chk("irq pin off", {15'h0, timerIrq}, 16'h0001);
    rd(ADDR_CMP_ONE_LO, 8'h10, "lo without arm");
    rd(ADDR_STATUS, 8'h40, "flag kept");
    rd(ADDR_CMP_ONE_LO, 8'h10, "lo after arm");
    rd(ADDR_STATUS, 8'h00, "flag gone");
    $display("test suppression and release done");
    wr(ADDR_CTRL_FIRST, 8'h06);
    wr(ADDR_CMP_ONE_LO, 8'h20);
    wr(ADDR_CTRL_SECOND, 8'ha0);
    @(posedge clk_sys);
    fireOne <= 1'b1;
    @(posedge clk_sys);
    fireOne <= 1'b0;
    tick(6);
    chk("pulse start", {15'h0, cmpPin[0]}, 16'h0001);
    rd(ADDR_CAP_ONE_HI, 8'hff, "cap1 hi");
    rd(ADDR_CAP_ONE_LO, 8'hfd, "cap1 lo");
    tick(80);
    chk("pulse end", {15'h0, cmpPin[0]}, 16'h0000);
    rd(ADDR_STATUS, 8'h80, "no cmp1 flag");
    wr(ADDR_CTRL_FIRST, 8'h0f);
    tick(1);
    chk("force ignored", {15'h0, cmpPin[0]}, 16'h0000);
    rd(ADDR_CAP_ONE_LO, 8'hfd, "cap1 clear");
    $display("test one pulse done");
    wr(ADDR_CTRL_FIRST, 8'h04);
    wr(ADDR_CMP_ONE_LO, 8'h08);
    wr(ADDR_CMP_TWO_HI, 8'h00);
    wr(ADDR_CMP_TWO_LO, 8'h20);
    // Divide by 2 matches as the counter enters the value, so its period is one tick shorter.
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_SECOND, {4'hb, 2'(i), 2'h0});
      wr(ADDR_CNT_LO, 8'h00);
      waitRise;
      waitRise;
      t0 = $time;
      waitRise;
      chk("pwm period", 16'(($time - t0) / 100), 16'((i == 0) ? 72 : (37 << (i + 1))));
    end
    rd(ADDR_STATUS, 8'h80, "period flag");
    $display("test pwm done");
    end_sim;
  end
endmodule
